// >>> bl_src_defs.vh
`ifndef BL_SRC_DEFS_VH
`define BL_SRC_DEFS_VH

`define ADDR_W 10
`define DATA_W 16

`define OFF_SOURCE_MODE 10'h020
`define OFF_GLOBAL_BRIGHTNESS 10'h028
`define OFF_MAP_LOW 10'h030
`define OFF_MAP_HIGH 10'h032
`define OFF_USER_SETTINGS_ONE 10'h040

`define RST_SOURCE_MODE 16'h0300
`define RST_MODE_RESERVED 14'h00c0
`define RST_GLOBAL_BRIGHTNESS 16'h0000
`define RST_MAP_LOW 16'h0000
`define RST_MAP_HIGH 16'h0000
`define RST_USER_SETTINGS_ONE 16'h00b0
`define RST_SOURCE_SEL 2'h0
`define RST_DITHER 3'h0
`define RST_THERMAL 1'b0
`define RST_SLOPE 3'h5
`define RST_SMOOTH 1'b1
`define RST_DIMMING 2'h0

`define SRC_SEL_LSB 0
`define SRC_SEL_MSB 1
`define SRC_PWM_INPUT 2'h0
`define SRC_REGISTER 2'h2

`define MAP_W 4
`define MAP_GLOBAL 4'h0
`define MAP_ZONE1 4'h1
`define MAP_ZONE2 4'h2
`define MAP_ZONE3 4'h3
`define MAP_ZONE4 4'h4
`define MAP_ZONE5 4'h5

`define DITHER_MSB 15
`define DITHER_LSB 13
`define THERMAL_BIT 9
`define SLOPE_MSB 7
`define SLOPE_LSB 5
`define SMOOTH_BIT 4
`define DIM_MSB 1
`define DIM_LSB 0

`define DIM_PWM 2'h0
`define DIM_HYBRID 2'h1
`define DIM_CURRENT 2'h3

`endif

// >>> backlight_brightness_source_regs.v
`timescale 1ns/10ps
`include "bl_src_defs.vh"

// Functional notes
// - Source field selects PWM input or register
// - Mode register resets 300h, reserved fixed
// - Sixteen-bit global brightness at 28h, resets zero
// - Four-bit map fields, outputs 0-3 low
// - Map 0h follows the global source
// - Codes 1h,4h,5h select zones 1,4,5
// - Code 2h taken as zone 2
// - Map high register holds outputs 4,5
// - User settings at 40h, reset B0h
// - Dimming mode PWM, hybrid or current
// - Five sixteen-bit zone brightness words selectable
module backlight_brightness_source_regs
(
	input wire ref_clk_i,
	input wire rst_i,
	input wire [`ADDR_W-1:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [`DATA_W-1:0] reg_wdata_i,
	input wire reg_rd_i,
	output reg [`DATA_W-1:0] reg_rdata_o,
	output reg reg_rvalid_o,
	input wire [`DATA_W-1:0] pwm_brightness_i,
	input wire [`DATA_W-1:0] zone1_brightness_i,
	input wire [`DATA_W-1:0] zone2_brightness_i,
	input wire [`DATA_W-1:0] zone3_brightness_i,
	input wire [`DATA_W-1:0] zone4_brightness_i,
	input wire [`DATA_W-1:0] zone5_brightness_i,
	output reg [6*`DATA_W-1:0] out_brightness_o,
	output reg [2:0] dither_select_o,
	output reg thermal_watch_on_o,
	output reg [2:0] slope_time_o,
	output reg smooth_fade_on_o,
	output reg [1:0] dimming_mode_o,
	output reg dim_hybrid_o,
	output reg dim_current_o
);

	reg [1:0] source_sel_q;
	reg [`DATA_W-1:0] global_brightness_q;
	reg [`DATA_W-1:0] led_source_map_low_q;
	reg [`DATA_W-1:0] led_source_map_high_q;
	reg [`DATA_W-1:0] user_settings_one_q;
	reg [`DATA_W-1:0] rdata_d;
	wire [`DATA_W-1:0] global_src;
	wire [6*`MAP_W-1:0] maps;
	wire [6*`DATA_W-1:0] out_brightness_d;
	wire wr_source_mode;
	wire wr_global_brightness;
	wire wr_map_low;
	wire wr_map_high;
	wire wr_user_settings_one;
	wire [`DATA_W-1:0] source_mode_rd;

	// One decoder shared by the write strobes and the read mux
	function addr_hit;
		input [`ADDR_W-1:0] addr;
		input [`ADDR_W-1:0] offset;
		begin
			addr_hit = (addr == offset);
		end
	endfunction

	assign wr_source_mode = reg_wr_i & addr_hit(reg_addr_i, `OFF_SOURCE_MODE);
	assign wr_global_brightness = reg_wr_i & addr_hit(reg_addr_i, `OFF_GLOBAL_BRIGHTNESS);
	assign wr_map_low = reg_wr_i & addr_hit(reg_addr_i, `OFF_MAP_LOW);
	assign wr_map_high = reg_wr_i & addr_hit(reg_addr_i, `OFF_MAP_HIGH);
	assign wr_user_settings_one = reg_wr_i & addr_hit(reg_addr_i, `OFF_USER_SETTINGS_ONE);

	// Reserved bits 15-2 are not stored: they always read C0h and ignore writes
	assign source_mode_rd = {`RST_MODE_RESERVED, source_sel_q};

	// Codes 1h and 3h are reserved; anything but the register code follows the pin
	assign global_src = (source_sel_q == `SRC_REGISTER) ? global_brightness_q : pwm_brightness_i;

	assign maps = {led_source_map_high_q[7:0], led_source_map_low_q};

	function [`DATA_W-1:0] pick_source;
		input [`MAP_W-1:0] code;
		input [`DATA_W-1:0] glob;
		input [`DATA_W-1:0] z1;
		input [`DATA_W-1:0] z2;
		input [`DATA_W-1:0] z3;
		input [`DATA_W-1:0] z4;
		input [`DATA_W-1:0] z5;
		begin
			case (code)
				`MAP_GLOBAL: pick_source = glob;
				`MAP_ZONE1: pick_source = z1;
				`MAP_ZONE2: pick_source = z2;
				`MAP_ZONE3: pick_source = z3;
				`MAP_ZONE4: pick_source = z4;
				`MAP_ZONE5: pick_source = z5;
				// Undefined codes fall back to the global source rather than dark
				default: pick_source = glob;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1)
		begin : g_out
			assign out_brightness_d[g*`DATA_W +: `DATA_W] = pick_source(maps[g*`MAP_W +: `MAP_W], global_src,
				zone1_brightness_i, zone2_brightness_i, zone3_brightness_i,
				zone4_brightness_i, zone5_brightness_i);
		end
	endgenerate

	// All six words share one flop bank so the output has a single driver
	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			out_brightness_o <= {(6*`DATA_W){1'b0}};
		end
		else
		begin
			out_brightness_o <= out_brightness_d;
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			source_sel_q <= `RST_SOURCE_SEL;
		end
		else if (wr_source_mode)
		begin
			source_sel_q <= reg_wdata_i[`SRC_SEL_MSB:`SRC_SEL_LSB];
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			global_brightness_q <= `RST_GLOBAL_BRIGHTNESS;
		end
		else if (wr_global_brightness)
		begin
			global_brightness_q <= reg_wdata_i;
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			led_source_map_low_q <= `RST_MAP_LOW;
		end
		else if (wr_map_low)
		begin
			led_source_map_low_q <= reg_wdata_i;
		end
	end

	// Reserved upper byte is kept as plain storage so it reads back
	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			led_source_map_high_q <= `RST_MAP_HIGH;
		end
		else if (wr_map_high)
		begin
			led_source_map_high_q <= reg_wdata_i;
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			user_settings_one_q <= `RST_USER_SETTINGS_ONE;
		end
		else if (wr_user_settings_one)
		begin
			user_settings_one_q <= reg_wdata_i;
		end
	end

	// Unmapped offsets read as zero
	always @*
	begin
		rdata_d = {`DATA_W{1'b0}};
		if (addr_hit(reg_addr_i, `OFF_SOURCE_MODE))
			rdata_d = source_mode_rd;
		else if (addr_hit(reg_addr_i, `OFF_GLOBAL_BRIGHTNESS))
			rdata_d = global_brightness_q;
		else if (addr_hit(reg_addr_i, `OFF_MAP_LOW))
			rdata_d = led_source_map_low_q;
		else if (addr_hit(reg_addr_i, `OFF_MAP_HIGH))
			rdata_d = led_source_map_high_q;
		else if (addr_hit(reg_addr_i, `OFF_USER_SETTINGS_ONE))
			rdata_d = user_settings_one_q;
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
		end
	end

	// Read has no side effect; data is held until the next read
	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			reg_rdata_o <= {`DATA_W{1'b0}};
		end
		else if (reg_rd_i)
		begin
			reg_rdata_o <= rdata_d;
		end
	end

	// Config outputs lag the register by one cycle so every output is a flop
	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dither_select_o <= `RST_DITHER;
		end
		else
		begin
			dither_select_o <= user_settings_one_q[`DITHER_MSB:`DITHER_LSB];
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			thermal_watch_on_o <= `RST_THERMAL;
		end
		else
		begin
			thermal_watch_on_o <= user_settings_one_q[`THERMAL_BIT];
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			slope_time_o <= `RST_SLOPE;
		end
		else
		begin
			slope_time_o <= user_settings_one_q[`SLOPE_MSB:`SLOPE_LSB];
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			smooth_fade_on_o <= `RST_SMOOTH;
		end
		else
		begin
			smooth_fade_on_o <= user_settings_one_q[`SMOOTH_BIT];
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dimming_mode_o <= `RST_DIMMING;
		end
		else
		begin
			dimming_mode_o <= user_settings_one_q[`DIM_MSB:`DIM_LSB];
		end
	end

	// Decoded flags save the consumer a compare; unused code 2h raises neither
	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dim_hybrid_o <= 1'b0;
		end
		else
		begin
			dim_hybrid_o <= (user_settings_one_q[`DIM_MSB:`DIM_LSB] == `DIM_HYBRID);
		end
	end

	always @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dim_current_o <= 1'b0;
		end
		else
		begin
			dim_current_o <= (user_settings_one_q[`DIM_MSB:`DIM_LSB] == `DIM_CURRENT);
		end
	end

endmodule // backlight_brightness_source_regs

// >>> bl_src_chk_sva.sv
`timescale 1ns/10ps
module bl_src_chk
(
	input wire ref_clk_i,
	input wire rst_i,
	input wire [9:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire reg_rvalid_o,
	input wire [15:0] zone1_brightness_i,
	input wire [95:0] out_brightness_o,
	input wire [2:0] slope_time_o,
	input wire smooth_fade_on_o,
	input wire [1:0] dimming_mode_o,
	input wire dim_hybrid_o,
	input wire dim_current_o
);
default clocking cb @(posedge ref_clk_i);
endclocking
default disable iff (rst_i);
AST_RV: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no rvalid");
AST_MODE: assert property (reg_rd_i && reg_addr_i == 10'h020 |=> reg_rdata_o[15:2] == 14'h00c0)
	else $error("mode top bits");
AST_UNM: assert property (reg_rd_i && reg_addr_i == 10'h3fe |=> reg_rdata_o == 16'h0000)
	else $error("unmapped read");
AST_HYB: assert property (dim_hybrid_o == (dimming_mode_o == 2'h1)) else $error("hybrid");
AST_CUR: assert property (dim_current_o == (dimming_mode_o == 2'h3)) else $error("current");
AST_CFG: assert property (reg_wr_i && reg_addr_i == 10'h040 |=> ##1
	{slope_time_o, dimming_mode_o} == {$past(reg_wdata_i[7:5], 2), $past(reg_wdata_i[1:0], 2)}) else $error("cfg");
AST_RST: assert property ($fell(rst_i) |-> slope_time_o == 3'h5 && smooth_fade_on_o) else $error("cfg reset");
AST_MAP: assert property (reg_wr_i && reg_addr_i == 10'h030 && reg_wdata_i == 16'h0001 ##1 !reg_wr_i |=>
	out_brightness_o[15:0] == $past(zone1_brightness_i)) else $error("zone1 route");
C_RV: cover property (reg_rvalid_o);
C_HYB: cover property (dim_hybrid_o);
C_CUR: cover property (dim_current_o);
endmodule // bl_src_chk
bind backlight_brightness_source_regs bl_src_chk u_chk (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
	.reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .zone1_brightness_i, .out_brightness_o, .slope_time_o,
	.smooth_fade_on_o, .dimming_mode_o, .dim_hybrid_o, .dim_current_o);

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
reg ref_clk_i = 1'b0;
reg rst_i = 1'b1;
reg reg_wr_i = 1'b0;
reg reg_rd_i = 1'b0;
reg [9:0] reg_addr_i = 10'h000;
reg [15:0] reg_wdata_i = 16'h0000;
reg [15:0] pwm_brightness_i = 16'h0111;
reg [15:0] zone1_brightness_i = 16'h1001;
reg [15:0] zone2_brightness_i = 16'h2002;
reg [15:0] zone3_brightness_i = 16'h3003;
reg [15:0] zone4_brightness_i = 16'h4004;
reg [15:0] zone5_brightness_i = 16'h5005;
wire [15:0] reg_rdata_o;
wire [95:0] out_brightness_o;
wire [2:0] dither_select_o;
wire [2:0] slope_time_o;
wire [1:0] dimming_mode_o;
wire reg_rvalid_o, thermal_watch_on_o, smooth_fade_on_o, dim_hybrid_o, dim_current_o;
integer num_errors = 0;
integer compares = 0;
integer i;
always #4 ref_clk_i = ~ref_clk_i;
backlight_brightness_source_regs u_dut (.ref_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
	.reg_rdata_o, .reg_rvalid_o, .pwm_brightness_i, .zone1_brightness_i, .zone2_brightness_i, .zone3_brightness_i,
	.zone4_brightness_i, .zone5_brightness_i, .out_brightness_o, .dither_select_o, .thermal_watch_on_o,
	.slope_time_o, .smooth_fade_on_o, .dimming_mode_o, .dim_hybrid_o, .dim_current_o);
task chk(input [95:0] s, input [95:0] e);
begin
	compares = compares + 1;
	if (s !== e)
	begin
		num_errors = num_errors + 1;
		$display("[ERR] %0t got %h exp %h", $time, s, e);
	end
end
endtask
// Strobe drops for a cycle between calls, so no edge sees two drivers
task wr(input [9:0] a, input [15:0] d);
begin
	@(posedge ref_clk_i);
	reg_addr_i <= a;
	reg_wdata_i <= d;
	reg_wr_i <= 1'b1;
	@(posedge ref_clk_i);
	reg_wr_i <= 1'b0;
end
endtask
task rd(input [9:0] a, input [15:0] e);
begin
	@(posedge ref_clk_i);
	reg_addr_i <= a;
	reg_rd_i <= 1'b1;
	@(posedge ref_clk_i);
	reg_rd_i <= 1'b0;
	#1;
	chk(reg_rvalid_o, 1'b1);
	chk(reg_rdata_o, e);
end
endtask
task settle;
begin
	repeat (2) @(posedge ref_clk_i);
	#1;
end
endtask
task end_of_test;
begin
	$display("errors %0d compares %0d", num_errors, compares);
	if (num_errors == 0 && compares > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
end
endtask
initial
begin
	#20000;
	num_errors = num_errors + 1;
	end_of_test;
end
initial
begin
	repeat (6) @(posedge ref_clk_i);
	rst_i <= 1'b0;
	pwm_brightness_i <= 16'h0777;
	settle;
	chk(out_brightness_o, {6{16'h0777}});
	chk({slope_time_o, smooth_fade_on_o}, 4'hb);
	rd(10'h020, 16'h0300);
	rd(10'h028, 16'h0000);
	rd(10'h030, 16'h0000);
	rd(10'h032, 16'h0000);
	rd(10'h040, 16'h00b0);
	rd(10'h3fe, 16'h0000);
	@(posedge ref_clk_i);
	#1;
	chk(reg_rvalid_o, 1'b0);
	$display("reset test done");
	wr(10'h020, 16'hfffe);
	rd(10'h020, 16'h0302);
	wr(10'h028, 16'h1234);
	rd(10'h028, 16'h1234);
	chk(out_brightness_o, {6{16'h1234}});
	wr(10'h030, 16'h0001);
	settle;
	chk(out_brightness_o[15:0], zone1_brightness_i);
	wr(10'h030, 16'h3210);
	wr(10'h032, 16'hab54);
	settle;
	chk(out_brightness_o, {16'h5005, 16'h4004, 16'h3003, 16'h2002, 16'h1001, 16'h1234});
	rd(10'h032, 16'hab54);
	wr(10'h030, 16'h00f6);
	wr(10'h020, 16'h0003);
	settle;
	chk(out_brightness_o[31:0], {2{16'h0777}});
	$display("map test done");
	for (i = 0; i < 4; i = i + 1)
	begin
		wr(10'h040, 16'ha2e0 | i);
		settle;
		chk({dither_select_o, thermal_watch_on_o, slope_time_o, smooth_fade_on_o, dimming_mode_o, dim_hybrid_o,
			dim_current_o}, {3'h5, 1'b1, 3'h7, 1'b0, i[1:0], i == 1, i == 3});
		rd(10'h040, 16'ha2e0 | i);
	end
	$display("config test done");
	end_of_test;
end
endmodule // tb_top
